// ---- rtl/sir_params.svh ----
// constants for the supply integrity and reset flag block
// assumes a 250 MHz CPU clock and a single APB-mapped register
`ifndef SIR_PARAMS_SVH
`define SIR_PARAMS_SVH

// register map
`define SIR_CSR_OFFSET      32'h0000_0000
`define SIR_ADDR_W          32

// field positions inside the control/status byte
`define SIR_BIT_IE          6
`define SIR_BIT_FLAG        5
`define SIR_BIT_LVRF        4
`define SIR_BIT_WDRF        0
`define SIR_CSR_RESET       8'h00

// timing
`define SIR_CLK_PERIOD_NS   4
`define SIR_DLY_SHORT       256
`define SIR_DLY_LONG        4096
`define SIR_FETCH_CYC       2
`define SIR_WDG_PULSE_NS    500
`define SIR_WDG_PULSE_CYC   ((`SIR_WDG_PULSE_NS + `SIR_CLK_PERIOD_NS - 1) / `SIR_CLK_PERIOD_NS)
`define SIR_GUARD_CYC       4
`define SIR_CNT_W           16
`define SIR_SYNC_W          4

`endif

// ---- rtl/sir_pkg.sv ----
// types shared by the supply integrity block
// assumes sir_params.svh is on the include path
`include "sir_params.svh"
`default_nettype none

package sir_pkg;

	typedef enum logic [1:0] {
		SIR_RUN    = 2'b00,
		SIR_ACTIVE = 2'b01,
		SIR_DELAY  = 2'b10,
		SIR_FETCH  = 2'b11
	} sir_phase_t;

	typedef enum logic [1:0] {
		SIR_SRC_EXT = 2'b00,
		SIR_SRC_LVD = 2'b01,
		SIR_SRC_WDG = 2'b10
	} sir_src_t;

	typedef struct packed {
		sir_phase_t             st;
		sir_src_t               src;
		logic [`SIR_CNT_W-1:0]  cnt;
		logic [2:0]             guard;
		logic                   lvd_act;
		logic                   flag;
		logic                   ie;
		logic                   pending;
		logic                   lvrf;
		logic                   wdrf;
		logic                   pin_oe;
		logic                   cpu_rst;
		logic                   vec_fetch;
		logic                   irq;
		logic                   wake;
		logic                   pready;
		logic                   pslverr;
		logic [31:0]            prdata;
	} sir_state_t;

endpackage

`default_nettype wire

// ---- rtl/sir_sync.sv ----
// two-flop synchroniser, one lane per bit
// assumes inputs are levels that stay put for several clocks
`default_nettype none

module sir_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);

	// first stage feeds only the second stage
	for (genvar i = 0; i < W; i++) begin : g_lane
		logic meta;
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				meta <= 1'b0;
				q[i] <= 1'b0;
			end else begin
				meta <= d[i];
				q[i] <= meta;
			end
		end
	end

endmodule

`default_nettype wire

// ---- rtl/sir_top.sv ----
// supply integrity: low-voltage reset, reset pin stretching,
// reset cause flags and supply early-warning interrupt
// assumes comparator and pin inputs are asynchronous levels, the
// watchdog underflow is a one-cycle pulse on CLK, APB master on CLK
//
// Our own choices: the APB register port and the placing of the registers.
`include "sir_params.svh"
`default_nettype none

// Summary of operation
// - undervoltage keeps the device in reset and drives the reset pin low
// - release uses the rising threshold, assertion the falling one
// - watchdog underflow drives the pin low for the minimum pulse width
// - bit 5 is a read-only live copy of the early-warning comparator
// - with bit 6 set, every flag change raises an interrupt request
// - pending interrupt clears when the CPU starts servicing it
// - interrupt reaches the CPU only if enabled and CPU mask cleared
// - early warning works only when low-voltage reset is enabled
// - wait mode keeps running and wakes; halt is not woken
// - register contents are frozen during halt
// - no warning interrupt for crossings during the post-reset delay
// - enabling while flag shows undervoltage gives an immediate interrupt
// - enabling after the rise gives no interrupt until the flag next changes
// - bit 4 set on low-voltage reset, cleared only by writing zero
// - bit 4 is meaningless when low-voltage reset is disabled
// - reset zeroes enable and reserved bits; cause flags keep source values
// - after the active phase wait 256 or 4096 cycles, then 2-cycle fetch
// - reset pin held low through the whole delay phase
// - bit 0 set on watchdog reset, cleared by writing zero or low-voltage reset
module sir_top
	import sir_pkg::*;
#(
	parameter logic [`SIR_CNT_W-1:0] DLY_SHORT     = `SIR_CNT_W'(`SIR_DLY_SHORT),
	parameter logic [`SIR_CNT_W-1:0] DLY_LONG      = `SIR_CNT_W'(`SIR_DLY_LONG),
	parameter logic [`SIR_CNT_W-1:0] WDG_PULSE_CYC = `SIR_CNT_W'(`SIR_WDG_PULSE_CYC)
) (
	input  wire logic                    CLK,
	input  wire logic                    RST_B,
	input  wire logic                    PSEL,
	input  wire logic                    PENABLE,
	input  wire logic                    PWRITE,
	input  wire logic [`SIR_ADDR_W-1:0]  PADDR,
	input  wire logic [31:0]             PWDATA,
	output var  logic [31:0]             PRDATA,
	output var  logic                    PREADY,
	output var  logic                    PSLVERR,
	input  wire logic                    LVD_ENABLE,
	input  wire logic                    LONG_DELAY,
	input  wire logic                    LVD_BELOW_RISE,
	input  wire logic                    LVD_BELOW_FALL,
	input  wire logic                    WARN_BELOW,
	input  wire logic                    WDG_UNDERFLOW,
	input  wire logic                    RSTPIN_IN,
	output var  logic                    RSTPIN_OUT,
	output var  logic                    RSTPIN_OE,
	output var  logic                    CPU_RESET,
	output var  logic                    VECTOR_FETCH,
	input  wire logic                    CPU_IMASK,
	input  wire logic                    IRQ_ACK,
	input  wire logic                    WAIT_MODE,
	input  wire logic                    HALT_MODE,
	output var  logic                    IRQ,
	output var  logic                    WAKE
);

	logic                     rst_meta;
	logic                     rst_n;
	logic [`SIR_SYNC_W-1:0]   sync_q;
	logic                     below_rise;
	logic                     below_fall;
	logic                     warn_live;
	logic                     pin_low;
	logic [`SIR_CNT_W-1:0]    dly_cyc;
	logic                     setup;
	logic                     wr;
	logic [7:0]               csr;
	sir_state_t               s;
	sir_state_t               next_s;

	// reset release through two flops, assertion stays asynchronous
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	sir_sync #(
		.W (`SIR_SYNC_W)
	) u_sync (
		.clk   (CLK),
		.rst_n (rst_n),
		.d     ({LVD_BELOW_RISE, LVD_BELOW_FALL, WARN_BELOW, ~RSTPIN_IN}),
		.q     (sync_q)
	);

	assign below_rise = sync_q[3];
	assign below_fall = sync_q[2];
	assign warn_live  = sync_q[1] & LVD_ENABLE;
	assign pin_low    = sync_q[0];
	assign dly_cyc    = LONG_DELAY ? DLY_LONG : DLY_SHORT;
	assign setup      = PSEL & ~PENABLE;
	assign wr         = PSEL & PENABLE & s.pready & PWRITE & ~s.pslverr;
	assign csr        = {1'b0, s.ie, s.flag, s.lvrf, 3'b000, s.wdrf};

	// next-state logic for the whole block
	always_comb begin
		next_s = s;

		// hysteresis between release and assertion thresholds
		if (!LVD_ENABLE) begin
			next_s.lvd_act = 1'b0;
		end else if (s.lvd_act) begin
			next_s.lvd_act = below_rise;
		end else begin
			next_s.lvd_act = below_fall;
		end

		// reset sequence phases
		case (s.st)
			SIR_RUN: begin
				if (s.guard != 3'd0) begin
					next_s.guard = s.guard - 3'd1;
				end
				// watchdog starts a timed pin pulse
				if (WDG_UNDERFLOW) begin
					next_s.st  = SIR_ACTIVE;
					next_s.src = SIR_SRC_WDG;
					next_s.cnt = WDG_PULSE_CYC - `SIR_CNT_W'(1);
				end else if (pin_low && s.guard == 3'd0) begin
					next_s.st  = SIR_ACTIVE;
					next_s.src = SIR_SRC_EXT;
				end
			end
			SIR_ACTIVE: begin
				// active phase ends, stabilisation delay starts
				if ((s.src == SIR_SRC_LVD && !s.lvd_act)
						|| (s.src == SIR_SRC_WDG && s.cnt == '0)
						|| (s.src == SIR_SRC_EXT && !pin_low)) begin
					next_s.st  = SIR_DELAY;
					next_s.cnt = dly_cyc - `SIR_CNT_W'(1);
				end else if (s.cnt != '0) begin
					next_s.cnt = s.cnt - `SIR_CNT_W'(1);
				end
			end
			SIR_DELAY: begin
				// count the delay, then the two-cycle fetch
				if (s.cnt == '0) begin
					next_s.st  = SIR_FETCH;
					next_s.cnt = `SIR_CNT_W'(`SIR_FETCH_CYC - 1);
				end else begin
					next_s.cnt = s.cnt - `SIR_CNT_W'(1);
				end
			end
			SIR_FETCH: begin
				// guard masks our own released low still in the synchroniser
				if (s.cnt == '0) begin
					next_s.st    = SIR_RUN;
					next_s.guard = 3'(`SIR_GUARD_CYC);
				end else begin
					next_s.cnt = s.cnt - `SIR_CNT_W'(1);
				end
			end
			default: begin
				next_s.st = SIR_ACTIVE;
			end
		endcase

		if (s.lvd_act && !(s.st == SIR_ACTIVE && s.src == SIR_SRC_LVD)) begin
			next_s.st  = SIR_ACTIVE;
			next_s.src = SIR_SRC_LVD;
			next_s.cnt = '0;
		end

		if (!HALT_MODE && s.st == SIR_RUN) begin
			next_s.flag = warn_live;
			if (wr && PADDR == `SIR_CSR_OFFSET) begin
				next_s.ie = PWDATA[`SIR_BIT_IE];
				// cleared by writing zero, a same-cycle set below wins
				if (!PWDATA[`SIR_BIT_LVRF]) begin
					next_s.lvrf = 1'b0;
				end
				if (!PWDATA[`SIR_BIT_WDRF] && !WDG_UNDERFLOW) begin
					next_s.wdrf = 1'b0;
				end
			end
			if (IRQ_ACK) begin
				next_s.pending = 1'b0;
			end
			// toggle of the flag raises a request
			// only counted in run phase, never during the delay
			if (s.ie && next_s.flag != s.flag && next_s.st == SIR_RUN) begin
				next_s.pending = 1'b1;
			end
			// enabling while flag high fires at once
			// enabling while flag low fires nothing
			if (!s.ie && next_s.ie && s.flag && next_s.st == SIR_RUN) begin
				next_s.pending = 1'b1;
			end
		end

		// sequence effects come after the register update, so a reset
		// starting in the same cycle beats any software write
		// any reset sequence clears the enable
		if (next_s.st != SIR_RUN) begin
			next_s.ie      = 1'b0;
			next_s.pending = 1'b0;
		end

		// low-voltage cause only recorded while low-voltage option is on
		// low-voltage reset clears the watchdog flag
		if (next_s.st == SIR_ACTIVE && next_s.src == SIR_SRC_LVD && LVD_ENABLE) begin
			next_s.lvrf = 1'b1;
			next_s.wdrf = 1'b0;
		end
		if (next_s.st == SIR_ACTIVE && next_s.src == SIR_SRC_WDG) begin
			next_s.wdrf = 1'b1;
		end

		// pin low through active (own sources) and delay
		next_s.pin_oe    = (next_s.st == SIR_ACTIVE && next_s.src != SIR_SRC_EXT)
		                   || next_s.st == SIR_DELAY;
		next_s.cpu_rst   = next_s.st == SIR_ACTIVE || next_s.st == SIR_DELAY;
		next_s.vec_fetch = next_s.st == SIR_FETCH;

		// request needs enable and unmasked CPU
		next_s.irq  = next_s.pending & next_s.ie & ~CPU_IMASK;
		// wake from wait only, halt is not left this way
		next_s.wake = next_s.pending & next_s.ie & WAIT_MODE & ~HALT_MODE;

		// apb slave: answer in the first access cycle
		next_s.pready  = setup;
		next_s.pslverr = setup && PADDR != `SIR_CSR_OFFSET;
		next_s.prdata  = (setup && PADDR == `SIR_CSR_OFFSET) ? {24'h00_0000, csr} : 32'h0000_0000;
	end

	// single state register; power-on starts as a low-voltage reset
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			s         <= '0;
			s.st      <= SIR_ACTIVE;
			s.src     <= SIR_SRC_LVD;
			s.lvd_act <= 1'b1;
			s.pin_oe  <= 1'b1;
			s.cpu_rst <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// outputs straight from the state flops; pin only ever pulls low
	assign PRDATA       = s.prdata;
	assign PREADY       = s.pready;
	assign PSLVERR      = s.pslverr;
	assign RSTPIN_OUT   = 1'b0;
	assign RSTPIN_OE    = s.pin_oe;
	assign CPU_RESET    = s.cpu_rst;
	assign VECTOR_FETCH = s.vec_fetch;
	assign IRQ          = s.irq;
	assign WAKE         = s.wake;

	// checks
	lvd_pin_low_a: assert property (@(posedge CLK) disable iff (!rst_n)
		$rose(s.lvd_act) |-> ##[1:2] (RSTPIN_OE && CPU_RESET))
		else $error("undervoltage did not pull the reset pin");

	hyst_hold_a: assert property (@(posedge CLK) disable iff (!rst_n)
		(s.lvd_act && below_rise && LVD_ENABLE) |=> s.lvd_act)
		else $error("low-voltage reset released below rising threshold");

	wdg_pulse_a: assert property (@(posedge CLK) disable iff (!rst_n)
		(s.st == SIR_RUN && WDG_UNDERFLOW && !s.lvd_act) |=> RSTPIN_OE [*4])
		else $error("watchdog pulse on reset pin too short");

	flag_copy_a: assert property (@(posedge CLK) disable iff (!rst_n)
		(!HALT_MODE && s.st == SIR_RUN && next_s.st == SIR_RUN) |=> (s.flag == $past(warn_live)))
		else $error("warning flag does not follow comparator");

	toggle_irq_a: assert property (@(posedge CLK) disable iff (!rst_n)
		($past(s.ie) && s.ie && $changed(s.flag) && s.st == SIR_RUN && !$past(CPU_IMASK)) |-> IRQ)
		else $error("flag toggle raised no request");

	ack_clear_a: assert property (@(posedge CLK) disable iff (!rst_n)
		(IRQ_ACK && !HALT_MODE && s.flag == warn_live && !(s.ie != next_s.ie)) |=> !s.pending)
		else $error("service did not clear pending request");

	mask_gate_a: assert property (@(posedge CLK) disable iff (!rst_n)
		IRQ |-> ($past(CPU_IMASK) == 1'b0 && s.ie))
		else $error("request passed while masked or disabled");

	halt_freeze_a: assert property (@(posedge CLK) disable iff (!rst_n)
		(HALT_MODE && s.st == SIR_RUN && next_s.st == SIR_RUN) |=> $stable(csr))
		else $error("register changed during halt");

	delay_pin_a: assert property (@(posedge CLK) disable iff (!rst_n)
		(s.st == SIR_DELAY) |-> (RSTPIN_OE && CPU_RESET))
		else $error("pin released during delay phase");

	fetch_len_a: assert property (@(posedge CLK) disable iff (!rst_n)
		$rose(VECTOR_FETCH) && !s.lvd_act && !next_s.lvd_act |=> VECTOR_FETCH ##1 !VECTOR_FETCH)
		else $error("vector fetch not two cycles");

	no_warn_off_a: assert property (@(posedge CLK) disable iff (!rst_n)
		(!LVD_ENABLE && !HALT_MODE && s.st == SIR_RUN) |=> !s.flag)
		else $error("warning active without low-voltage option");

	lvrf_set_a: assert property (@(posedge CLK) disable iff (!rst_n)
		($past(rst_n) && $past(LVD_ENABLE) && s.st == SIR_ACTIVE && s.src == SIR_SRC_LVD) |-> s.lvrf)
		else $error("low-voltage reset did not set its cause flag");

	wdrf_set_a: assert property (@(posedge CLK) disable iff (!rst_n)
		(s.st == SIR_ACTIVE && s.src == SIR_SRC_WDG) |-> s.wdrf)
		else $error("watchdog reset did not set its cause flag");

	seq_clear_a: assert property (@(posedge CLK) disable iff (!rst_n)
		(s.st != SIR_RUN) |-> (!s.ie && !s.pending))
		else $error("enable or pending kept through a reset sequence");

	delay_irq_a: assert property (@(posedge CLK) disable iff (!rst_n)
		(s.st != SIR_RUN) |=> !IRQ)
		else $error("warning request raised during reset sequence");

	wake_mode_a: assert property (@(posedge CLK) disable iff (!rst_n)
		WAKE |-> ($past(WAIT_MODE) && !$past(HALT_MODE)))
		else $error("wake raised outside wait or during halt");

endmodule

`default_nettype wire

// ---- tb/sir_pin_model.sv ----
// far side of the reset pin: pull-up plus an external circuit that may pull low
// assumes the device drives low only while its enable is high
`default_nettype none

module sir_pin_model (
	input  wire logic oe,
	input  wire logic drv,
	input  wire logic ext_low,
	output var  logic pin
);
	timeunit 1ns;
	timeprecision 100ps;

	// wired-and pin
	// released pin goes to the pull-up level, never holds a stale value
	always_comb pin = !((oe && !drv) || ext_low);
endmodule

`default_nettype wire

// ---- tb/tb_supply_integrity_reset_flags.sv ----
// bench for the supply integrity block: reset sequences, cause flags, warning irq
// assumes sir_top with shortened counts and sir_pin_model on the reset pin
`include "sir_params.svh"
`default_nettype none

module tb_supply_integrity_reset_flags;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [15:0] DS = 16'h0008;
	localparam logic [15:0] DL = 16'h0010;
	localparam logic [15:0] WP = 16'h0005;
	localparam logic [31:0] A0 = `SIR_CSR_OFFSET;

	logic        CLK, RST_B, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, e;
	logic [31:0] PADDR, PWDATA, PRDATA, r;
	logic        LVD_ENABLE, LONG_DELAY, LVD_BELOW_RISE, LVD_BELOW_FALL, WARN_BELOW;
	logic        WDG_UNDERFLOW, RSTPIN_IN, RSTPIN_OUT, RSTPIN_OE, CPU_RESET, VECTOR_FETCH;
	logic        CPU_IMASK, IRQ_ACK, WAIT_MODE, HALT_MODE, IRQ, WAKE, ext_low;
	int          bad_count, n_tests, cyc, cr, oe, vf;

	sir_top #(.DLY_SHORT(DS), .DLY_LONG(DL), .WDG_PULSE_CYC(WP)) uut (
		.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.LVD_ENABLE(LVD_ENABLE), .LONG_DELAY(LONG_DELAY), .LVD_BELOW_RISE(LVD_BELOW_RISE),
		.LVD_BELOW_FALL(LVD_BELOW_FALL), .WARN_BELOW(WARN_BELOW), .WDG_UNDERFLOW(WDG_UNDERFLOW),
		.RSTPIN_IN(RSTPIN_IN), .RSTPIN_OUT(RSTPIN_OUT), .RSTPIN_OE(RSTPIN_OE),
		.CPU_RESET(CPU_RESET), .VECTOR_FETCH(VECTOR_FETCH), .CPU_IMASK(CPU_IMASK),
		.IRQ_ACK(IRQ_ACK), .WAIT_MODE(WAIT_MODE), .HALT_MODE(HALT_MODE), .IRQ(IRQ), .WAKE(WAKE)
	);

	sir_pin_model pin_m (.oe(RSTPIN_OE), .drv(RSTPIN_OUT), .ext_low(ext_low), .pin(RSTPIN_IN));

	// 250 MHz clock
	initial begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// hang guard, far above the longest sequence
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			stop_test();
		end
	end

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge CLK);
	endtask

	// one APB transfer; an edge first so psel never toggles twice in a step
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge CLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		// no cycle count assumed; only the hang guard ends a stuck wait
		do begin
			@(posedge CLK);
		end while (PREADY !== 1'b1);
		r = PRDATA;
		e = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask

	task automatic rdc(input string nm, input logic [7:0] x);
		apb(1'b0, A0, 32'h0000_0000);
		chk(nm, r, {24'h0000_00, x});
	endtask

	task automatic ack();
		IRQ_ACK <= 1'b1;
		tick(1);
		IRQ_ACK <= 1'b0;
		tick(3);
	endtask

	// counts reset cycles, pin-driven cycles and fetch cycles of one sequence
	task automatic seq();
		cr = 0;
		oe = 0;
		vf = 0;
		@(posedge CLK);
		while (CPU_RESET === 1'b1 && cr < 10000) begin
			if (RSTPIN_OE === 1'b1)
				oe++;
			cr++;
			@(posedge CLK);
		end
		while (VECTOR_FETCH === 1'b1 && vf < 9) begin
			vf++;
			@(posedge CLK);
		end
	endtask

	task automatic t_flags();
		rdc("csr_por", 8'h10);
		apb(1'b1, A0, 32'h0000_0011);
		rdc("csr_set_one", 8'h10);
		apb(1'b1, A0, 32'h0000_0000);
		rdc("csr_clear", 8'h00);
		apb(1'b0, A0 + 32'h0000_0004, 32'h0000_0000);
		chk("bad_addr_err", e, 1);
		chk("bad_addr_data", r, 0);
	endtask

	task automatic t_irq();
		apb(1'b1, A0, 32'h0000_0040);
		tick(3);
		chk("irq_en_low", IRQ, 0);
		WARN_BELOW <= 1'b1;
		tick(8);
		chk("irq_fall", IRQ, 1);
		rdc("csr_flag", 8'h60);
		ack();
		chk("irq_ack", IRQ, 0);
		CPU_IMASK <= 1'b1;
		WAIT_MODE <= 1'b1;
		WARN_BELOW <= 1'b0;
		tick(8);
		chk("irq_masked", IRQ, 0);
		chk("wake_wait", WAKE, 1);
		HALT_MODE <= 1'b1;
		tick(3);
		chk("wake_halt", WAKE, 0);
		apb(1'b1, A0, 32'h0000_0000);
		rdc("csr_halt", 8'h40);
		HALT_MODE <= 1'b0;
		WAIT_MODE <= 1'b0;
		CPU_IMASK <= 1'b0;
		tick(3);
		chk("irq_rise", IRQ, 1);
		ack();
		apb(1'b1, A0, 32'h0000_0000);
		WARN_BELOW <= 1'b1;
		tick(8);
		chk("irq_off", IRQ, 0);
		apb(1'b1, A0, 32'h0000_0040);
		tick(3);
		chk("irq_enable", IRQ, 1);
		ack();
		WARN_BELOW <= 1'b0;
		tick(8);
		chk("irq_second", IRQ, 1);
		ack();
		LVD_ENABLE <= 1'b0;
		WARN_BELOW <= 1'b1;
		tick(8);
		chk("irq_no_lvd", IRQ, 0);
		WARN_BELOW <= 1'b0;
		tick(4);
		LVD_ENABLE <= 1'b1;
		tick(4);
	endtask

	task automatic t_wdg();
		WDG_UNDERFLOW <= 1'b1;
		tick(1);
		WDG_UNDERFLOW <= 1'b0;
		seq();
		chk("wdg_rst", cr, WP + DS);
		chk("wdg_pin", oe, WP + DS);
		chk("wdg_fetch", vf, 2);
		rdc("csr_wdg", 8'h01);
	endtask

	task automatic t_lvd();
		WARN_BELOW <= 1'b1;
		LVD_BELOW_RISE <= 1'b1;
		LVD_BELOW_FALL <= 1'b1;
		tick(6);
		chk("lvd_rst", CPU_RESET, 1);
		chk("lvd_pin", RSTPIN_IN, 0);
		LVD_BELOW_FALL <= 1'b0;
		tick(10);
		chk("lvd_hyst", CPU_RESET, 1);
		LONG_DELAY <= 1'b1;
		LVD_BELOW_RISE <= 1'b0;
		WARN_BELOW <= 1'b0;
		seq();
		chk("lvd_long", cr >= DL && cr <= DL + 6, 1);
		chk("lvd_pin_dly", oe, cr);
		chk("lvd_fetch", vf, 2);
		rdc("csr_lvd", 8'h10);
		chk("lvd_no_irq", IRQ, 0);
		LONG_DELAY <= 1'b0;
	endtask

	task automatic t_ext();
		tick(6);
		ext_low <= 1'b1;
		tick(6);
		ext_low <= 1'b0;
		seq();
		chk("ext_pin_dly", oe, DS);
		chk("ext_rst", cr >= DS && cr <= DS + 4, 1);
		rdc("csr_ext", 8'h10);
	endtask

	// main sequence
	initial begin
		{RST_B, PSEL, PENABLE, PWRITE, WDG_UNDERFLOW, IRQ_ACK, ext_low} = '0;
		{LONG_DELAY, LVD_BELOW_RISE, LVD_BELOW_FALL, WARN_BELOW, WAIT_MODE, HALT_MODE} = '0;
		{PADDR, PWDATA} = '0;
		LVD_ENABLE = 1'b1;
		CPU_IMASK = 1'b0;
		{bad_count, n_tests, cyc} = '0;
		tick(4);
		RST_B <= 1'b1;
		seq();
		chk("por_fetch", vf, 2);
		t_flags();
		t_irq();
		t_wdg();
		t_lvd();
		t_ext();
		stop_test();
	end
endmodule

`default_nettype wire
